// File: src/mqd_pkg.sv
// package: register map, field layout and constants of the quadrature decoder
`default_nettype none
package mqd_pkg;
	// ***********************************
	// register byte offsets
	// ***********************************
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_COUNT_X  = 8'h08;
	localparam logic [7:0] REG_COUNT_Y  = 8'h0C;
	localparam logic [7:0] REG_COUNT_Z  = 8'h10;
	localparam logic [7:0] REG_PERIOD0  = 8'h20;
	localparam logic [7:0] REG_ON0      = 8'h30;
	localparam logic [7:0] REG_OFF0     = 8'h40;
	localparam logic [7:0] REG_OUTCFG0  = 8'h50;
	localparam logic [7:0] REG_SAMPSEL  = 8'h60;
	localparam int         REG_STRIDE   = 4;
	// ***********************************
	// control fields
	// ***********************************
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_XA_ALT   = 1;
	localparam int CTRL_XB_ALT   = 2;
	localparam int CTRL_YA_ALT   = 3;
	localparam int CTRL_YB_ALT   = 4;
	localparam int CTRL_ZA_ALT   = 5;
	localparam int CTRL_ZB_ALT   = 6;
	localparam int CTRL_WIDTH    = 7;
	// output config: bit0 polarity (1 = active low), bits2:1 off state
	localparam int OCFG_POL      = 0;
	localparam int OCFG_OFF_LO   = 1;
	localparam int OCFG_WIDTH    = 3;
	localparam logic [1:0] OFF_HIZ  = 2'h0;
	localparam logic [1:0] OFF_HIGH = 2'h1;
	localparam logic [1:0] OFF_LOW  = 2'h2;
	// ***********************************
	// sizes and reset values
	// ***********************************
	localparam int NUM_PWM       = 4;
	localparam int NUM_AXES      = 3;
	localparam int PWM_WIDTH     = 16;
	localparam int COUNT_WIDTH   = 16;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
	typedef enum logic [1:0] {MQD_STEP_NONE, MQD_STEP_UP, MQD_STEP_DOWN} mqd_step_t;
endpackage
`default_nettype wire

// File: src/mqd_top.sv
// quadrature decoder with four staggered pwm timers and high-current outputs
// Summary of operation
// - sample axis pairs autonomously by hardware
// - x inputs each select between two pins
// - y inputs each select between two pins
// - z inputs each select between two pins
// - four high-current control outputs
// - per-output programmable on and off times
// - per-axis programmable sampling instant
// - per-output selectable active polarity
// - off state hi-z, high or low
// - four independent 16-bit pwm timers
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none
module mqd_top #(
	parameter int NPWM = mqd_pkg::NUM_PWM,
	parameter int PW   = mqd_pkg::PWM_WIDTH,
	parameter int CW   = mqd_pkg::COUNT_WIDTH
) (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [2:0]  PIN_PHASE_A,
	input  wire logic [2:0]  PIN_PHASE_A_ALT,
	input  wire logic [2:0]  PIN_PHASE_B,
	input  wire logic [2:0]  PIN_PHASE_B_ALT,
	output logic [NPWM-1:0]  HIGH_CURRENT_OUTPUT,
	output logic [NPWM-1:0]  HIGH_CURRENT_OE
);
	localparam int NAX = mqd_pkg::NUM_AXES;

	// ***********************************
	// apb decode
	// ***********************************
	logic [mqd_pkg::CTRL_WIDTH-1:0] ctrl_ff;
	logic [PW-1:0]                  period_ff [NPWM];
	logic [PW-1:0]                  on_ff     [NPWM];
	logic [PW-1:0]                  off_ff    [NPWM];
	logic [mqd_pkg::OCFG_WIDTH-1:0] ocfg_ff   [NPWM];
	logic [1:0]                     sampsel_ff[NAX];
	logic [PW-1:0]                  tmr_ff    [NPWM];
	logic signed [CW-1:0]           count_ff  [NAX];

	wire        access  = PSEL && PENABLE;
	wire        wr_acc  = access && PWRITE;
	wire        rd_setup = PSEL && !PENABLE && !PWRITE;
	wire        hit_ctl = PADDR == mqd_pkg::REG_CTRL;
	wire        hit_sts = PADDR == mqd_pkg::REG_STATUS;
	wire        hit_ss  = PADDR == mqd_pkg::REG_SAMPSEL;

	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base, input int n);
		in_bank = (a >= base) && (a < base + 8'(n * mqd_pkg::REG_STRIDE)) && (a[1:0] == 2'h0);
	endfunction

	function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
		bank_idx = int'(a - base) / mqd_pkg::REG_STRIDE;
	endfunction

	function automatic logic [1:0] off_mode(input logic [mqd_pkg::OCFG_WIDTH-1:0] cfg);
		off_mode = cfg[mqd_pkg::OCFG_OFF_LO +: 2];
	endfunction

	wire hit_cnt = in_bank(PADDR, mqd_pkg::REG_COUNT_X, NAX);
	wire hit_per = in_bank(PADDR, mqd_pkg::REG_PERIOD0, NPWM);
	wire hit_on  = in_bank(PADDR, mqd_pkg::REG_ON0, NPWM);
	wire hit_off = in_bank(PADDR, mqd_pkg::REG_OFF0, NPWM);
	wire hit_cfg = in_bank(PADDR, mqd_pkg::REG_OUTCFG0, NPWM);
	wire mapped  = hit_ctl || hit_sts || hit_ss || hit_cnt || hit_per || hit_on
		|| hit_off || hit_cfg;
	wire [31:0] sampsel_word = {26'h0, sampsel_ff[2], sampsel_ff[1], sampsel_ff[0]};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = mqd_pkg::UNMAPPED_VALUE;
		if (hit_ctl) begin
			rd_mux = 32'(ctrl_ff);
		end else if (hit_sts) begin
			rd_mux = 32'(HIGH_CURRENT_OUTPUT);
		end else if (hit_ss) begin
			rd_mux = sampsel_word;
		end else if (hit_cnt) begin
			rd_mux = 32'(signed'(count_ff[bank_idx(PADDR, mqd_pkg::REG_COUNT_X)]));
		end else if (hit_per) begin
			rd_mux = 32'(period_ff[bank_idx(PADDR, mqd_pkg::REG_PERIOD0)]);
		end else if (hit_on) begin
			rd_mux = 32'(on_ff[bank_idx(PADDR, mqd_pkg::REG_ON0)]);
		end else if (hit_off) begin
			rd_mux = 32'(off_ff[bank_idx(PADDR, mqd_pkg::REG_OFF0)]);
		end else if (hit_cfg) begin
			rd_mux = 32'(ocfg_ff[bank_idx(PADDR, mqd_pkg::REG_OUTCFG0)]);
		end
	end

	// zero-wait slave: ready every cycle, error only on unmapped access
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PRDATA  <= 32'h0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= 1'b1;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			PRDATA  <= rd_setup ? rd_mux : PRDATA;
		end
	end

	// ***********************************
	// configuration registers
	// ***********************************
	wire wr_ok = wr_acc && PREADY;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_ff <= '0;
			for (int i = 0; i < NAX; i++) sampsel_ff[i] <= 2'(i);
			for (int i = 0; i < NPWM; i++) begin
				period_ff[i] <= mqd_pkg::PERIOD_RST;
				on_ff[i]     <= '0;
				off_ff[i]    <= '0;
				ocfg_ff[i]   <= '0;
			end
		end else if (wr_ok) begin
			if (hit_ctl) ctrl_ff <= PWDATA[mqd_pkg::CTRL_WIDTH-1:0];
			if (hit_ss) for (int i = 0; i < NAX; i++) sampsel_ff[i] <= PWDATA[2*i +: 2];
			if (hit_per) period_ff[bank_idx(PADDR, mqd_pkg::REG_PERIOD0)] <= PWDATA[PW-1:0];
			if (hit_on) on_ff[bank_idx(PADDR, mqd_pkg::REG_ON0)] <= PWDATA[PW-1:0];
			if (hit_off) off_ff[bank_idx(PADDR, mqd_pkg::REG_OFF0)] <= PWDATA[PW-1:0];
			if (hit_cfg) ocfg_ff[bank_idx(PADDR, mqd_pkg::REG_OUTCFG0)] <=
				PWDATA[mqd_pkg::OCFG_WIDTH-1:0];
		end
	end

	// ***********************************
	// pwm timers and high-current outputs
	// ***********************************
	wire enable = ctrl_ff[mqd_pkg::CTRL_ENABLE];
	logic [NPWM-1:0] active;
	logic [NPWM-1:0] wrap;
	logic [NPWM-1:0] nxt_out;
	logic [NPWM-1:0] nxt_oe;
	always_comb begin
		for (int i = 0; i < NPWM; i++) begin
			wrap[i]   = tmr_ff[i] >= period_ff[i];
			// window [on, off); on after off wraps through the period end
			active[i] = enable && ((on_ff[i] <= off_ff[i]) ?
				(tmr_ff[i] >= on_ff[i] && tmr_ff[i] < off_ff[i]) :
				(tmr_ff[i] >= on_ff[i] || tmr_ff[i] < off_ff[i]));
			nxt_out[i] = active[i] ? !ocfg_ff[i][mqd_pkg::OCFG_POL]
				: (off_mode(ocfg_ff[i]) == mqd_pkg::OFF_HIGH);
			nxt_oe[i]  = active[i] || (off_mode(ocfg_ff[i]) != mqd_pkg::OFF_HIZ);
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < NPWM; i++) tmr_ff[i] <= '0;
		end else begin
			for (int i = 0; i < NPWM; i++) tmr_ff[i] <= (!enable || wrap[i]) ? '0 : tmr_ff[i] + 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			HIGH_CURRENT_OUTPUT <= '0;
			HIGH_CURRENT_OE     <= '0;
		end else begin
			HIGH_CURRENT_OUTPUT <= nxt_out;
			HIGH_CURRENT_OE     <= nxt_oe;
		end
	end

	// ***********************************
	// input selection and synchronisers
	// ***********************************
	// alternate pin choice per phase
	wire [NAX-1:0] alt_a = {ctrl_ff[mqd_pkg::CTRL_ZA_ALT], ctrl_ff[mqd_pkg::CTRL_YA_ALT],
		ctrl_ff[mqd_pkg::CTRL_XA_ALT]};
	wire [NAX-1:0] alt_b = {ctrl_ff[mqd_pkg::CTRL_ZB_ALT], ctrl_ff[mqd_pkg::CTRL_YB_ALT],
		ctrl_ff[mqd_pkg::CTRL_XB_ALT]};
	logic [11:0] sync1_ff;
	logic [11:0] sync2_ff;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {PIN_PHASE_B_ALT, PIN_PHASE_B, PIN_PHASE_A_ALT, PIN_PHASE_A};
			sync2_ff <= sync1_ff;
		end
	end
	wire [NAX-1:0] phase_a = (alt_a & sync2_ff[5:3]) | (~alt_a & sync2_ff[2:0]);
	wire [NAX-1:0] phase_b = (alt_b & sync2_ff[11:9]) | (~alt_b & sync2_ff[8:6]);

	// ***********************************
	// sampling and decoding
	// ***********************************
	function automatic mqd_pkg::mqd_step_t gray_step(input logic [1:0] prev, input logic [1:0] cur);
		logic [3:0] t;
		t = {prev, cur};
		case (t)
			4'h1, 4'h7, 4'hE, 4'h8: gray_step = mqd_pkg::MQD_STEP_UP;
			4'h2, 4'hB, 4'hD, 4'h4: gray_step = mqd_pkg::MQD_STEP_DOWN;
			default: gray_step = mqd_pkg::MQD_STEP_NONE;
		endcase
	endfunction

	logic [1:0] last_ff [NAX];
	logic [NAX-1:0] sample;
	logic [NAX-1:0] rd_clear;
	mqd_pkg::mqd_step_t step [NAX];
	always_comb begin
		for (int i = 0; i < NAX; i++) begin
			// sample when the selected timer wraps
			sample[i]   = enable && wrap[sampsel_ff[i]];
			step[i]     = gray_step(last_ff[i], {phase_a[i], phase_b[i]});
			// clear where the word is latched: no step slips in between
			rd_clear[i] = rd_setup && hit_cnt
				&& bank_idx(PADDR, mqd_pkg::REG_COUNT_X) == i;
		end
	end

	// hardware sampling, count, clear on read
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < NAX; i++) begin
				last_ff[i]  <= '0;
				count_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NAX; i++) begin
				if (sample[i]) last_ff[i] <= {phase_a[i], phase_b[i]};
				// a step landing on the clearing read is kept, not lost
				if (sample[i] && step[i] == mqd_pkg::MQD_STEP_UP)
					count_ff[i] <= (rd_clear[i] ? '0 : count_ff[i]) + 1'b1;
				else if (sample[i] && step[i] == mqd_pkg::MQD_STEP_DOWN)
					count_ff[i] <= (rd_clear[i] ? '0 : count_ff[i]) - 1'b1;
				else if (rd_clear[i])
					count_ff[i] <= '0;
			end
		end
	end

	// ***********************************
	// checks
	// ***********************************
	sequence wr_ctrl_s;
		wr_ok && hit_ctl;
	endsequence
	timer_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
		wrap[0] |=> tmr_ff[0] == '0) else $error("timer did not restart");
	out_pol_a: assert property (@(posedge CLK) disable iff (RESET)
		active[0] |=> HIGH_CURRENT_OE[0] && HIGH_CURRENT_OUTPUT[0] == !$past(ocfg_ff[0][0]))
		else $error("active level wrong");
	off_hiz_a: assert property (@(posedge CLK) disable iff (RESET)
		(!active[1] && off_mode(ocfg_ff[1]) == mqd_pkg::OFF_HIZ) |=> !HIGH_CURRENT_OE[1])
		else $error("off state not released");
	cnt_clear_a: assert property (@(posedge CLK) disable iff (RESET)
		(rd_clear[0] && !sample[0]) |=> count_ff[0] == '0) else $error("count not cleared");
	cnt_up_a: assert property (@(posedge CLK) disable iff (RESET)
		(sample[1] && step[1] == mqd_pkg::MQD_STEP_UP && !rd_clear[1])
		|=> count_ff[1] == $past(count_ff[1]) + 1'b1) else $error("count not stepped");
	cnt_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		(!sample[2] && !rd_clear[2]) |=> $stable(count_ff[2])) else $error("count moved");
	ctrl_wr_a: assert property (@(posedge CLK) disable iff (RESET)
		wr_ctrl_s |=> ctrl_ff == $past(PWDATA[mqd_pkg::CTRL_WIDTH-1:0]))
		else $error("control not written");
	sel_alt_a: assert property (@(posedge CLK) disable iff (RESET)
		alt_a[1] |-> phase_a[1] == sync2_ff[4]) else $error("wrong pin selected");
	sel_def_a: assert property (@(posedge CLK) disable iff (RESET)
		!alt_b[2] |-> phase_b[2] == sync2_ff[8]) else $error("default pin not used");
	pready_hi_a: assert property (@(posedge CLK) disable iff (RESET)
		1'b1 |=> PREADY) else $error("bus not ready");
	slv_err_a: assert property (@(posedge CLK) disable iff (RESET)
		(PSEL && !PENABLE && !mapped) |=> PSLVERR) else $error("unmapped access not flagged");
	tmr_run_a: assert property (@(posedge CLK) disable iff (RESET)
		(enable && !wrap[1]) |=> tmr_ff[1] == $past(tmr_ff[1]) + 1'b1)
		else $error("timer did not advance");
	tmr_idle_a: assert property (@(posedge CLK) disable iff (RESET)
		!enable |=> tmr_ff[3] == '0) else $error("timer ran while disabled");
	off_low_a: assert property (@(posedge CLK) disable iff (RESET)
		(!active[2] && off_mode(ocfg_ff[2]) == mqd_pkg::OFF_LOW)
		|=> HIGH_CURRENT_OE[2] && !HIGH_CURRENT_OUTPUT[2]) else $error("off state not low");
	off_high_a: assert property (@(posedge CLK) disable iff (RESET)
		(!active[3] && off_mode(ocfg_ff[3]) == mqd_pkg::OFF_HIGH)
		|=> HIGH_CURRENT_OE[3] && HIGH_CURRENT_OUTPUT[3]) else $error("off state not high");
	act_low_a: assert property (@(posedge CLK) disable iff (RESET)
		(active[1] && ocfg_ff[1][mqd_pkg::OCFG_POL])
		|=> HIGH_CURRENT_OE[1] && !HIGH_CURRENT_OUTPUT[1])
		else $error("active low level wrong");
	cnt_down_a: assert property (@(posedge CLK) disable iff (RESET)
		(sample[2] && step[2] == mqd_pkg::MQD_STEP_DOWN && !rd_clear[2])
		|=> count_ff[2] == $past(count_ff[2]) - 1'b1) else $error("count not stepped down");
	dbl_skip_a: assert property (@(posedge CLK) disable iff (RESET)
		(sample[0] && step[0] == mqd_pkg::MQD_STEP_NONE && !rd_clear[0])
		|=> $stable(count_ff[0])) else $error("ignored step counted");
endmodule
`default_nettype wire

// File: tb/mqd_phase_model.sv
// far-side model: quadrature emitter and photodetector pairs of the three axes
`default_nettype none
module mqd_phase_model (
	input  wire logic       clk,
	input  wire logic [2:0] go,
	input  wire logic [2:0] up,
	input  wire logic [2:0] dbl,
	input  wire logic [5:0] use_alt,
	output logic      [2:0] pin_a,
	output logic      [2:0] pin_a_alt,
	output logic      [2:0] pin_b,
	output logic      [2:0] pin_b_alt
);
	logic [1:0] pos_ff [3] = '{2'h0, 2'h0, 2'h0};
	logic       junk_ff    = 1'b0;
	logic [2:0] ph_a;
	logic [2:0] ph_b;
	// a double step flips both phases at once, which a real wheel never should
	always_ff @(posedge clk) begin
		junk_ff <= ~junk_ff;
		for (int k = 0; k < 3; k++)
			if (go[k])
				pos_ff[k] <= pos_ff[k] + (dbl[k] ? 2'h2 : (up[k] ? 2'h1 : 2'h3));
	end
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			ph_a[k] = pos_ff[k][1];
			ph_b[k] = pos_ff[k][1] ^ pos_ff[k][0];
			pin_a[k] = use_alt[2*k] ? junk_ff : ph_a[k];
			pin_a_alt[k] = use_alt[2*k] ? ph_a[k] : ~junk_ff;
			pin_b[k] = use_alt[2*k+1] ? junk_ff : ph_b[k];
			pin_b_alt[k] = use_alt[2*k+1] ? ph_b[k] : ~junk_ff;
		end
	end
endmodule
`default_nettype wire

// File: tb/mqd_top_bench.sv
// bench: apb driver, quadrature stimulus and high-current output checks
`default_nettype none
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module mqd_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk       = 1'b0;
	logic        reset     = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [2:0]  go        = 3'h0;
	logic [2:0]  up        = 3'h0;
	logic [2:0]  dbl       = 3'h0;
	logic [5:0]  alt       = 6'h00;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er;
	logic [2:0]  pa, pa_alt, pb, pb_alt;
	logic [3:0]  hc, hc_oe;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          seed      = 32'h53A3;
	int          expc [3];
	int          offs [4];
	int          ons [4];
	int          act [4];
	logic [2:0]  ocfg [4]  = '{{mqd_pkg::OFF_HIZ, 1'b0}, {mqd_pkg::OFF_HIZ, 1'b1},
		{mqd_pkg::OFF_LOW, 1'b0}, {mqd_pkg::OFF_HIGH, 1'b1}};
	mqd_top mqd_top_i (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PIN_PHASE_A(pa), .PIN_PHASE_A_ALT(pa_alt), .PIN_PHASE_B(pb),
		.PIN_PHASE_B_ALT(pb_alt), .HIGH_CURRENT_OUTPUT(hc), .HIGH_CURRENT_OE(hc_oe));
	mqd_phase_model mqd_phase_model_i (.clk(clk), .go(go), .up(up), .dbl(dbl), .use_alt(alt),
		.pin_a(pa), .pin_a_alt(pa_alt), .pin_b(pb), .pin_b_alt(pb_alt));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard: the whole run needs under two thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			summarize();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CMP(rd, e)
	endtask
	// a step must be held past one timer wrap plus the synchroniser
	task automatic step(input logic [2:0] u, input logic [2:0] d, input logic [2:0] g);
		@(posedge clk);
		go <= g;
		up <= u;
		dbl <= d;
		@(posedge clk);
		go <= 3'h0;
		repeat (20) @(posedge clk);
	endtask
	initial begin
		logic [2:0] u, d, g;
		logic [5:0] a6;
		logic [1:0] ov;
		int         n;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++)
			rchk(mqd_pkg::REG_PERIOD0 + 8'(4 * i), 32'h0000FFFF);
		rchk(mqd_pkg::REG_SAMPSEL, 32'h00000024);
		rchk(mqd_pkg::REG_CTRL, 32'h00000000);
		`CMP(er, 1'b0)
		rchk(8'h7C, mqd_pkg::UNMAPPED_VALUE);
		`CMP(er, 1'b1)
		step(3'h1, 3'h0, 3'h1);
		rchk(mqd_pkg::REG_COUNT_X, 32'h0);
		$display("test reset and disabled done");
		for (int i = 0; i < 4; i++) begin
			// staggered windows; the last one always runs through the period end
			ons[i] = 2 * i + 1;
			offs[i] = (ons[i] + 1 + $unsigned($random(seed)) % 6) % 8;
			apb(1'b1, mqd_pkg::REG_PERIOD0 + 8'(4 * i), 32'h7);
			apb(1'b1, mqd_pkg::REG_ON0 + 8'(4 * i), 32'(ons[i]));
			apb(1'b1, mqd_pkg::REG_OFF0 + 8'(4 * i), 32'(offs[i]));
			apb(1'b1, mqd_pkg::REG_OUTCFG0 + 8'(4 * i), 32'(ocfg[i]));
			act[i] = 0;
		end
		apb(1'b1, mqd_pkg::REG_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			for (int i = 0; i < 4; i++) begin
				ov = ocfg[i][2:1] == mqd_pkg::OFF_HIZ ? {1'b0, hc[i]}
					: {1'b1, ocfg[i][2:1] == mqd_pkg::OFF_HIGH};
				if (hc_oe[i] === 1'b1 && hc[i] === ~ocfg[i][0])
					act[i]++;
				else
					`CMP({hc_oe[i], hc[i]}, ov)
			end
		end
		for (int i = 0; i < 4; i++)
			`CMP(act[i], ons[i] <= offs[i] ? offs[i] - ons[i] : 8 - ons[i] + offs[i])
		$display("test high-current outputs done");
		for (int t = 0; t < 6; t++) begin
			a6 = 6'($random(seed));
			apb(1'b1, mqd_pkg::REG_CTRL, {25'h0, a6, 1'b1});
			alt <= a6;
			apb(1'b1, mqd_pkg::REG_SAMPSEL, 32'($random(seed)) & 32'h3F);
			repeat (20) @(posedge clk);
			for (int k = 0; k < 3; k++) begin
				apb(1'b0, mqd_pkg::REG_COUNT_X + 8'(4 * k), 32'h0);
				expc[k] = 0;
			end
			n = 1 + $unsigned($random(seed)) % 8;
			repeat (n) begin
				u = 3'($random(seed));
				d = 3'($random(seed)) & 3'($random(seed));
				g = 3'($random(seed));
				for (int k = 0; k < 3; k++)
					if (g[k] && !d[k])
						expc[k] += u[k] ? 1 : -1;
				step(u, d, g);
			end
			for (int k = 0; k < 3; k++) begin
				rchk(mqd_pkg::REG_COUNT_X + 8'(4 * k), 32'(expc[k]));
				rchk(mqd_pkg::REG_COUNT_X + 8'(4 * k), 32'h0);
			end
			$display("test count round %0d done", t);
		end
		summarize();
	end
endmodule
`default_nettype wire
